// ---- verilog/ulp_power_mode_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module ulp_power_mode_control
  import ulp_host_pkg::*;
#(
  parameter int QUIET_CYCLES = INT_QUIET_CYCLES,
  parameter int WAKE_CYCLES  = WAKE_WAIT_CYCLES
)(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic       cmd_polarity,
  input  wire logic       cmd_bypass,
  input  wire logic       cmd_keep_match,
  output logic            cmd_ready,
  output logic            done,
  output logic [1:0]      result,
  output logic            regs_unreliable,
  output logic            device_reset_req,
  output logic            reg_wr,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic       reg_ack,
  output logic            power_pin,
  input  wire logic       irq_n_pin,
  output logic            low_power
);
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CHECK,
    ST_WRITE,
    ST_PIN_LOW,
    ST_PIN_HIGH,
    ST_QUIET,
    ST_RESUME_LOW,
    ST_WAIT_IRQ,
    ST_FINISH
  } state_e;

  localparam int         CNT_W      = 32;
  localparam logic [2:0] STEP_LAST  = 3'h7;

  state_e          state;
  logic [2:0]      step;
  logic [1:0]      op;
  logic            pol;
  logic            byp;
  logic            keep;
  logic [CNT_W-1:0] count;
  logic            irq_level;
  logic            irq_active;
  logic [7:0]      w_addr [8];
  logic [7:0]      w_data [8];
  logic [7:0]      ctrl_pol;
  logic [7:0]      ctrl_enter;
  logic [7:0]      master_val;
  logic [7:0]      mask_val;
  logic            quiet_done;
  logic            wake_done;

  // ----------------------------------------
  // Interrupt pin synchroniser
  // ----------------------------------------
  pin_sync3 u_irq_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (irq_n_pin),
    .level   (irq_level)
  );
  assign irq_active = ~irq_level;

  // ----------------------------------------
  // Write sequence tables
  // ----------------------------------------
  function automatic logic [7:0] bit_at(input int pos, input logic v);
    bit_at = v ? (8'h01 << pos) : 8'h00;
  endfunction

  // Reserved bit 2 and bits 7:5 always written as zero
  assign ctrl_pol   = bit_at(POS_PORT_MATCH_POLARITY, pol);
  // Clock disable only alongside port match enable
  assign ctrl_enter = ctrl_pol
                    | bit_at(POS_PORT_MATCH_ENABLE, 1'b1)
                    | bit_at(POS_LCD_ENABLE, op == CMD_ENTER_LCD)
                    | bit_at(POS_CLOCK_DISABLE, op == CMD_ENTER_SHUTDOWN);
  assign master_val = bit_at(POS_CLOCK_BYPASS, byp);
  // Mask reset in shutdown, or when match wake is unwanted
  assign mask_val   = bit_at(POS_PORT_MASK_RESET,
                             op == CMD_ENTER_SHUTDOWN || !keep);

  // Steps 0-5 before the pin goes low, steps 6 and 7 after
  assign w_addr[0] = IRQ_ENABLE_LOW_ADDR;
  assign w_data[0] = IRQ_ENABLE_ULP_VALUE[7:0];
  assign w_addr[1] = IRQ_ENABLE_HIGH_ADDR;
  assign w_data[1] = IRQ_ENABLE_ULP_VALUE[15:8];
  assign w_addr[2] = ULP_MODE_CONTROL_ADDR;
  assign w_data[2] = mask_val;
  assign w_addr[3] = MISCELLANEOUS_CONFIG_ADDR;
  assign w_data[3] = MISC_CONFIG_ULP_VALUE;
  assign w_addr[4] = MASTER_CONTROL_ADDR;
  assign w_data[4] = master_val;
  assign w_addr[5] = ULP_MODE_CONTROL_ADDR;
  assign w_data[5] = ctrl_pol;
  assign w_addr[6] = ULP_MODE_CONTROL_ADDR;
  assign w_data[6] = ctrl_enter;
  assign w_addr[7] = INDIRECT_CLOCK_CTRL_ADDR;
  assign w_data[7] = CLOCK_OFF_VALUE;

  assign quiet_done = (count >= CNT_W'(QUIET_CYCLES - 1));
  assign wake_done  = (count >= CNT_W'(WAKE_CYCLES - 1));
  assign cmd_ready  = (state == ST_IDLE);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      step             <= 3'h0;
      op               <= CMD_ENTER_CLOCK;
      pol              <= 1'b0;
      byp              <= 1'b0;
      keep             <= 1'b0;
      count            <= '0;
      done             <= 1'b0;
      result           <= RES_OK;
      regs_unreliable  <= 1'b0;
      device_reset_req <= 1'b0;
      reg_wr           <= 1'b0;
      reg_addr         <= 8'h00;
      reg_wdata        <= 8'h00;
      power_pin        <= 1'b0;
      low_power        <= 1'b0;
    end else begin
      done             <= 1'b0;
      device_reset_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            op   <= cmd_op;
            pol  <= cmd_polarity;
            byp  <= cmd_bypass;
            keep <= cmd_keep_match;
            if (cmd_op == CMD_RESUME) begin
              state <= ST_RESUME_LOW;
            end else begin
              step  <= 3'h0;
              state <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          // Pending wake event blocks entry
          if (irq_active) begin
            result <= RES_BUSY;
            state  <= ST_FINISH;
          end else begin
            reg_wr    <= 1'b1;
            reg_addr  <= w_addr[0];
            reg_wdata <= w_data[0];
            state     <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (reg_ack) begin
            reg_wr <= 1'b0;
            if (step == 3'h5) begin
              state <= ST_PIN_LOW;
            end else if (step == 3'h6) begin
              step  <= step + 3'h1;
              if (byp && op != CMD_ENTER_SHUTDOWN) begin
                reg_wr    <= 1'b1;
                reg_addr  <= w_addr[STEP_LAST];
                reg_wdata <= w_data[STEP_LAST];
              end else begin
                state <= ST_PIN_HIGH;
              end
            end else if (step == STEP_LAST) begin
              state <= ST_PIN_HIGH;
            end else begin
              step      <= step + 3'h1;
              reg_wr    <= 1'b1;
              reg_addr  <= w_addr[step + 3'h1];
              reg_wdata <= w_data[step + 3'h1];
            end
          end
        end
        ST_PIN_LOW: begin
          power_pin <= 1'b0;
          step      <= 3'h6;
          reg_wr    <= 1'b1;
          reg_addr  <= w_addr[6];
          reg_wdata <= w_data[6];
          state     <= ST_WRITE;
        end
        ST_PIN_HIGH: begin
          power_pin <= 1'b1;
          count     <= '0;
          state     <= ST_QUIET;
        end
        ST_QUIET: begin
          if (irq_active) begin
            // Treat as entered then woke
            regs_unreliable  <= 1'b1;
            device_reset_req <= (op == CMD_ENTER_SHUTDOWN);
            result           <= RES_WOKE;
            power_pin        <= 1'b0;
            state            <= ST_FINISH;
          end else if (quiet_done) begin
            low_power <= 1'b1;
            result    <= RES_OK;
            state     <= ST_FINISH;
          end else begin
            count <= count + CNT_W'(1);
          end
        end
        ST_RESUME_LOW: begin
          power_pin <= 1'b0;
          count     <= '0;
          state     <= ST_WAIT_IRQ;
        end
        ST_WAIT_IRQ: begin
          if (irq_active) begin
            regs_unreliable <= 1'b1;
            low_power       <= 1'b0;
            result          <= RES_OK;
            state           <= ST_FINISH;
          end else if (wake_done) begin
            result <= RES_TIMEOUT;
            state  <= ST_FINISH;
          end else begin
            count <= count + CNT_W'(1);
          end
        end
        ST_FINISH: begin
          done  <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  quiet_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(low_power) |-> $past(state) == ST_QUIET && $past(quiet_done))
    else $error("low power declared before quiet time");
  pin_low_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_wdata[POS_PORT_MATCH_ENABLE]
     && reg_addr == ULP_MODE_CONTROL_ADDR && step == 3'h6) |-> !power_pin)
    else $error("enable written with pin high");
  disable_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == ULP_MODE_CONTROL_ADDR
     && reg_wdata[POS_CLOCK_DISABLE]) |-> reg_wdata[POS_PORT_MATCH_ENABLE])
    else $error("clock disable without port match enable");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == ULP_MODE_CONTROL_ADDR) |->
      reg_wdata[2] == 1'b0 && reg_wdata[7:5] == 3'h0)
    else $error("reserved control bits written nonzero");
  busy_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_CHECK && irq_active) |=> state == ST_FINISH && !reg_wr)
    else $error("entry attempted with pending wake");
  woke_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_QUIET && irq_active) |=> regs_unreliable && !power_pin)
    else $error("wake after entry not flagged");
  shut_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_QUIET && irq_active && op == CMD_ENTER_SHUTDOWN)
      |=> device_reset_req ##1 !device_reset_req)
    else $error("shutdown retry reset missing");
  resume_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_WAIT_IRQ |-> !power_pin)
    else $error("pin high while waiting for wake");
  irq_enables_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == IRQ_ENABLE_HIGH_ADDR) |->
      reg_wdata == IRQ_ENABLE_ULP_VALUE[15:8])
    else $error("wrong interrupt enable value");
  write_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && !reg_ack) |=>
      reg_wr && $stable(reg_addr) && $stable(reg_wdata))
    else $error("write request dropped before acknowledge");
  pin_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(power_pin) |-> !reg_wr && state == ST_QUIET)
    else $error("pin raised with write outstanding");
  quiet_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_QUIET && !irq_active && !quiet_done) |=> state == ST_QUIET)
    else $error("quiet window cut short");
  shut_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && step == 3'h2 && op == CMD_ENTER_SHUTDOWN) |->
      reg_addr == ULP_MODE_CONTROL_ADDR && reg_wdata[POS_PORT_MASK_RESET])
    else $error("port mask not reset before shutdown");
  resume_done_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_WAIT_IRQ && irq_active) |=>
      state == ST_FINISH && !low_power && regs_unreliable)
    else $error("resume not completed on interrupt");
  clock_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == INDIRECT_CLOCK_CTRL_ADDR) |->
      reg_wdata == CLOCK_OFF_VALUE && byp && op != CMD_ENTER_SHUTDOWN)
    else $error("clock control written out of turn");
endmodule
`default_nettype wire

// ---- verilog/ulp_host_pkg.sv ----
// Behaviour
// - Host writes 0x1900 enables, 0x80 config, pin low, port match enable, pin high.
// - Host checks no pending events, then interrupt stays clear for 100 us.
// - Interrupt seen after entry means entered and woke; state unreliable.
// - Resume: pin low, wait for interrupt, reinitialise unpreserved registers; the host only sets regs_unreliable and writes no register.
// - With clock bypass (not shutdown), clock stopped via indirect clock control 0x00, not ULP clock disable.
// - Shutdown: enables, mask reset, config, pin low, disable plus enable, high.
// - Interrupt after shutdown attempt: reset device and repeat shutdown; the host pulses device_reset_req, ends with RES_WOKE and does not repeat.
// - Host clears every port mask bit before shutdown.
// - A write setting ULP clock disable also sets port match enable.
// - Host sets polarity in an earlier write than the mode enable.
// - Control bits 7:5 read zero; bit 2 reserved, host writes zero.
// - Host keeps match, alarm and fail interrupts enabled in ULP.
package ulp_host_pkg;
  localparam logic [7:0]  ULP_MODE_CONTROL_ADDR     = 8'hA2;
  localparam logic [7:0]  ULP_MODE_CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  IRQ_ENABLE_LOW_ADDR       = 8'h00;
  localparam logic [7:0]  IRQ_ENABLE_HIGH_ADDR      = 8'h01;
  localparam logic [15:0] IRQ_ENABLE_ULP_VALUE      = 16'h1900;
  localparam logic [7:0]  MISCELLANEOUS_CONFIG_ADDR = 8'h02;
  localparam logic [7:0]  MISC_CONFIG_ULP_VALUE     = 8'h80;
  localparam logic [7:0]  MASTER_CONTROL_ADDR       = 8'hA0;
  localparam logic [7:0]  INDIRECT_CLOCK_CTRL_ADDR  = 8'h03;
  localparam logic [7:0]  CLOCK_OFF_VALUE           = 8'h00;
  localparam int          POS_PORT_MATCH_POLARITY   = 0;
  localparam int          POS_PORT_MATCH_ENABLE     = 1;
  localparam int          POS_PORT_MASK_RESET       = 1;
  localparam int          POS_LCD_ENABLE            = 3;
  localparam int          POS_CLOCK_DISABLE         = 4;
  localparam int          POS_CLOCK_BYPASS          = 7;
  localparam int          CLK_SYS_MHZ               = 250;
  localparam int          INT_QUIET_US              = 100;
  localparam int          INT_QUIET_CYCLES          = INT_QUIET_US * CLK_SYS_MHZ;
  localparam int          WAKE_WAIT_US              = 1000;
  localparam int          WAKE_WAIT_CYCLES          = WAKE_WAIT_US * CLK_SYS_MHZ;
  typedef enum logic [1:0] {
    CMD_ENTER_CLOCK,
    CMD_ENTER_SHUTDOWN,
    CMD_RESUME,
    CMD_ENTER_LCD
  } command_e;
  typedef enum logic [1:0] {
    RES_OK,
    RES_WOKE,
    RES_TIMEOUT,
    RES_BUSY
  } result_e;
endpackage

// ---- verilog/pin_sync3.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_sync3
  import ulp_host_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  // ----------------------------------------
  // Three stages, change when two agree
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/ulp_device_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ulp_device_model
  import ulp_host_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic            reg_ack,
  input  wire logic       power_pin,
  output logic            irq_n_pin,
  input  wire logic       pending,
  input  wire logic       wake_req,
  input  wire logic       irq_clear,
  output logic            in_ulp,
  output logic            in_off,
  output logic [7:0]      ctrl
);
  logic       pin_q;
  logic       woke;
  logic [1:0] wait_cnt;
  wire        rise = power_pin & ~pin_q;
  wire        fall = ~power_pin & pin_q;
  wire        wr_ctrl = reg_wr & reg_ack & (reg_addr == ULP_MODE_CONTROL_ADDR);
  assign irq_n_pin = ~(pending | woke);
  // ---------------------------------------------------------------
  // Register access and power state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {pin_q, woke, reg_ack, in_ulp, in_off} <= '0;
      wait_cnt <= '0;
      ctrl <= ULP_MODE_CONTROL_RESET;
    end else begin
      pin_q <= power_pin;
      reg_ack <= reg_wr & ~reg_ack & (wait_cnt == 2'd0);
      if (reg_wr & ~reg_ack) begin
        wait_cnt <= (wait_cnt == 2'd0) ? 2'($urandom_range(3)) : wait_cnt - 2'd1;
      end
      if (wr_ctrl) begin
        ctrl <= {3'h0, reg_wdata[4:3], 1'b0, reg_wdata[1:0]};
      end
      if (irq_clear) begin
        woke <= 1'b0;
      end
      if (rise & (ctrl[1] | ctrl[3]) & ~pending) begin
        in_ulp <= 1'b1;
        in_off <= ctrl[4];
      end
      if (in_ulp & ~in_off & (wake_req | fall)) begin
        in_ulp <= 1'b0;
        ctrl[3] <= 1'b0;
        ctrl[1] <= 1'b0;
        woke <= 1'b1;
      end
      if (in_off & wake_req) begin
        woke <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/ulp_power_mode_control_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module ulp_power_mode_control_tb_top import ulp_host_pkg::*;;
  logic        clk_sys, rst, cmd_valid, cmd_polarity, cmd_bypass;
  logic        cmd_keep_match, cmd_ready, done, regs_unreliable;
  logic        device_reset_req, reg_wr, reg_ack, power_pin, irq_n_pin;
  logic        low_power, pending, wake_req, irq_clear, in_ulp, in_off;
  logic        pol, byp, keep;
  logic        pin_d = 1'b0;
  logic [1:0]  cmd_op, result, op;
  logic [7:0]  reg_addr, reg_wdata, ctrl;
  logic [15:0] log_q[$], exp_q[$];
  int          error_cnt, num_checks, rr_cnt;
  ulp_power_mode_control #(.QUIET_CYCLES(20), .WAKE_CYCLES(50)) dut (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_polarity(cmd_polarity), .cmd_bypass(cmd_bypass),
    .cmd_keep_match(cmd_keep_match), .cmd_ready(cmd_ready), .done(done),
    .result(result), .regs_unreliable(regs_unreliable),
    .device_reset_req(device_reset_req), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .power_pin(power_pin), .irq_n_pin(irq_n_pin), .low_power(low_power));
  ulp_device_model model (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .power_pin(power_pin),
    .irq_n_pin(irq_n_pin), .pending(pending), .wake_req(wake_req),
    .irq_clear(irq_clear), .in_ulp(in_ulp), .in_off(in_off), .ctrl(ctrl));
  // ---------------------------------------------------------------
  // Clock, monitor and helpers
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reg_wr && reg_ack) log_q.push_back({reg_addr, reg_wdata});
    if (power_pin !== pin_d) log_q.push_back({15'h7F80, power_pin});
    if (device_reset_req) rr_cnt++;
    pin_d <= power_pin;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic reset_all(input int n);
    rst = 1'b1;
    tick(n);
    rst = 1'b0;
    tick(5);
  endtask
  task automatic clear_irq;
    irq_clear = 1'b1;
    tick(1);
    irq_clear = 1'b0;
    tick(5);
  endtask
  task automatic run(input logic [1:0] o, input logic p, b, k);
    int n;
    log_q = {};
    {cmd_op, cmd_polarity, cmd_bypass, cmd_keep_match} = {o, p, b, k};
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask
  function automatic void build(input logic [1:0] o, input logic p, b, k);
    logic off;
    off = (o == CMD_ENTER_SHUTDOWN);
    exp_q = {};
    exp_q.push_back({IRQ_ENABLE_LOW_ADDR, IRQ_ENABLE_ULP_VALUE[7:0]});
    exp_q.push_back({IRQ_ENABLE_HIGH_ADDR, IRQ_ENABLE_ULP_VALUE[15:8]});
    exp_q.push_back({ULP_MODE_CONTROL_ADDR, 6'h00, !k || off, 1'b0});
    exp_q.push_back({MISCELLANEOUS_CONFIG_ADDR, MISC_CONFIG_ULP_VALUE});
    exp_q.push_back({MASTER_CONTROL_ADDR, b, 7'h00});
    exp_q.push_back({ULP_MODE_CONTROL_ADDR, 7'h00, p});
    exp_q.push_back({ULP_MODE_CONTROL_ADDR, 3'h0, off, o == CMD_ENTER_LCD,
                     2'h1, p});
    if (b && !off) exp_q.push_back({INDIRECT_CLOCK_CTRL_ADDR, CLOCK_OFF_VALUE});
    exp_q.push_back(16'hFF01);
  endfunction
  task automatic check_seq(input logic [1:0] o, input logic p, b, k);
    logic [15:0] seen;
    build(o, p, b, k);
    check(16'(log_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) begin
      seen = (i < log_q.size()) ? log_q[i] : 16'hXXXX;
      check(seen, exp_q[i]);
    end
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {cmd_valid, cmd_op, cmd_polarity, cmd_bypass, cmd_keep_match} = '0;
    {pending, wake_req, irq_clear} = '0;
    void'($urandom(32'h3A0B));
    reset_all(20);
    check(16'({cmd_ready, power_pin, low_power, reg_wr, ctrl}), 16'h800);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      op = i[0] ? CMD_ENTER_LCD : CMD_ENTER_CLOCK;
      {pol, byp, keep} = 3'($urandom_range(7));
      run(op, pol, byp, keep);
      check(16'(result), 16'(RES_OK));
      check_seq(op, pol, byp, keep);
      check(16'({low_power, in_ulp, ctrl[0]}), {13'h0, 2'h3, pol});
      run(CMD_RESUME, pol, byp, keep);
      check(16'(result), 16'(RES_OK));
      check(log_q[0], 16'hFF00);
      check(16'({low_power, ctrl[3], ctrl[1], in_ulp}), 16'h0);
      clear_irq();
    end
    $display("test entry and resume done");
    run(CMD_ENTER_CLOCK, 1'b0, 1'b0, 1'b1);
    wake_req = 1'b1;
    tick(2);
    wake_req = 1'b0;
    tick(5);
    check(16'({irq_n_pin, in_ulp, ctrl[1]}), 16'h0);
    run(CMD_RESUME, 1'b0, 1'b0, 1'b1);
    check(16'(result), 16'(RES_OK));
    clear_irq();
    $display("test wake event done");
    pending = 1'b1;
    tick(5);
    run(CMD_ENTER_CLOCK, 1'b1, 1'b0, 1'b0);
    check(16'(result), 16'(RES_BUSY));
    check(16'(log_q.size()), 16'h0);
    pending = 1'b0;
    tick(5);
    $display("test pending refusal done");
    wake_req = 1'b1;
    run(CMD_ENTER_CLOCK, 1'b0, 1'b0, 1'b1);
    check(16'(result), 16'(RES_WOKE));
    check(16'(regs_unreliable), 16'h1);
    wake_req = 1'b0;
    clear_irq();
    reset_all(2);
    $display("test quiet window done");
    run(CMD_ENTER_SHUTDOWN, 1'b1, 1'b1, 1'b1);
    check(16'(result), 16'(RES_OK));
    check_seq(CMD_ENTER_SHUTDOWN, 1'b1, 1'b1, 1'b1);
    check(16'(in_off), 16'h1);
    run(CMD_RESUME, 1'b1, 1'b1, 1'b1);
    check(16'(result), 16'(RES_TIMEOUT));
    reset_all(2);
    $display("test shutdown done");
    wake_req = 1'b1;
    rr_cnt = 0;
    run(CMD_ENTER_SHUTDOWN, 1'b0, 1'b0, 1'b0);
    check(16'(result), 16'(RES_WOKE));
    check(16'(rr_cnt), 16'h1);
    wake_req = 1'b0;
    $display("test shutdown retry done");
    end_sim();
  end
endmodule
`default_nettype wire
